// ### rtl/sml_limits.sv
// Purpose: Brake timing, regen dump, comm watchdog, overspeed and rate limits of a servo drive
// Assumes: Setting ports are in range; limit switch is an asynchronous pin
// Notes: Summary of operation
`timescale 1ns/10ps
module sml_limits
    import sml_pkg::*;
#(
    parameter int MS_DIV = MS_CYCLES
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic signed [SPEED_W-1:0] motor_speed,
    input wire logic error_active,
    input wire logic [14:0] error_brake_time_param,
    input wire logic [SPEED_W-1:0] zero_speed_threshold,
    input wire logic [1:0] error_brake_action_select,
    input wire logic [5:0] brake_activation_speed,
    input wire logic [9:0] bus_voltage,
    input wire logic [9:0] dump_voltage_level,
    input wire logic net_msg_strobe,
    input wire logic [13:0] comm_watchdog_time,
    input wire logic [4:0] comm_watchdog_action,
    input wire logic comm_loss_clear,
    input wire logic [6:0] max_velocity_setting,
    input wire logic overspeed_clear,
    input wire logic [RATE_W-1:0] max_accel_setting,
    input wire logic [RATE_W-1:0] commanded_rate,
    input wire logic estop_cmd,
    input wire logic limit_switch_pin,
    input wire logic jog_active,
    input wire logic osc_mode_active,
    input wire logic jog_speed_wr,
    input wire logic signed [7:0] jog_speed_wdata,
    input wire logic jog_accel_wr,
    input wire logic jog_accel_query,
    input wire logic jog_decel_wr,
    input wire logic [RATE_W-1:0] jog_rate_wdata,
    input wire logic [6:0] jerk_time_setting,
    input wire logic signed [POS_W-1:0] cmd_position,
    output logic dyn_brake_on,
    output logic regen_on,
    output logic comm_loss,
    output logic [4:0] comm_loss_action,
    output logic overspeed_alarm,
    output logic [RATE_W-1:0] active_rate,
    output logic signed [7:0] jog_speed_setting,
    output logic jog_reverse,
    output logic [RATE_W-1:0] jog_accel_setting,
    output logic [RATE_W-1:0] jog_decel_setting,
    output logic jog_query_valid,
    output logic [RATE_W-1:0] jog_query_data,
    output logic jog_write_refused,
    output logic signed [POS_W-1:0] filtered_position
);
    sml_jerk_if jif();

    // Millisecond divider
    logic [17:0] div_cnt;
    logic [17:0] next_div_cnt;
    logic ms_tick;

    always_comb
    begin
        ms_tick = (div_cnt == 18'(MS_DIV - 1));
        next_div_cnt = ms_tick ? 18'h00000 : div_cnt + 18'h00001;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            div_cnt <= '0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
        end
    end

    // Limit switch synchroniser
    logic lim_meta;
    logic lim_sync;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            lim_meta <= 1'b0;
            lim_sync <= 1'b0;
        end
        else
        begin
            lim_meta <= limit_switch_pin;
            lim_sync <= lim_meta;
        end
    end

    // Error deceleration brake sequencing
    sml_brake_state_type state;
    sml_brake_state_type next_state;
    logic [14:0] elapsed;
    logic [14:0] next_elapsed;
    logic brake_req;
    logic next_brake_req;
    logic [SPEED_W-1:0] speed_mag;
    logic decel_done;

    always_comb
    begin
        speed_mag = sml_abs(motor_speed);
        decel_done = (speed_mag <= zero_speed_threshold)
            || (elapsed >= error_brake_time_param);
        next_state = state;
        next_elapsed = elapsed;
        next_brake_req = 1'b0;
        unique case (state)
            SML_IDLE:
            begin
                next_elapsed = '0;
                if (error_active)
                begin
                    next_state = SML_DECEL;
                end
            end
            SML_DECEL:
            begin
                if (!error_active)
                begin
                    next_state = SML_IDLE;
                end
                else if (decel_done)
                begin
                    next_state = SML_STOP;
                    next_brake_req = error_brake_action_select[SEL_STOP_BIT];
                end
                else
                begin
                    next_brake_req = error_brake_action_select[SEL_DECEL_BIT];
                    if (ms_tick)
                    begin
                        next_elapsed = elapsed + 15'h0001;
                    end
                end
            end
            SML_STOP:
            begin
                next_brake_req = error_brake_action_select[SEL_STOP_BIT];
                if (!error_active)
                begin
                    next_state = SML_IDLE;
                    next_brake_req = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= SML_IDLE;
            elapsed <= '0;
            brake_req <= 1'b0;
        end
        else
        begin
            state <= next_state;
            elapsed <= next_elapsed;
            brake_req <= next_brake_req;
        end
    end

    // Comm watchdog, armed by the first message
    logic [13:0] wd_cnt;
    logic [13:0] next_wd_cnt;
    logic wd_armed;
    logic next_wd_armed;
    logic next_comm_loss;
    logic [4:0] next_comm_loss_action;
    logic wd_expire;

    always_comb
    begin
        next_wd_cnt = wd_cnt;
        next_wd_armed = wd_armed;
        wd_expire = 1'b0;
        if (net_msg_strobe)
        begin
            next_wd_cnt = comm_watchdog_time;
            next_wd_armed = (comm_watchdog_time != 14'h0000);
        end
        else if (wd_armed && ms_tick)
        begin
            next_wd_cnt = wd_cnt - 14'h0001;
            if (wd_cnt == 14'h0001)
            begin
                wd_expire = 1'b1;
                next_wd_armed = 1'b0;
            end
        end
        next_comm_loss = comm_loss;
        next_comm_loss_action = comm_loss_action;
        if (comm_loss_clear)
        begin
            next_comm_loss = 1'b0;
        end
        if (wd_expire)
        begin
            // Expiry wins over a clear in the same cycle
            next_comm_loss = 1'b1;
            next_comm_loss_action = comm_watchdog_action;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wd_cnt <= WDOG_TIME_RESET;
            wd_armed <= 1'b0;
            comm_loss <= 1'b0;
            comm_loss_action <= WDOG_ACTION_RESET;
        end
        else
        begin
            wd_cnt <= next_wd_cnt;
            wd_armed <= next_wd_armed;
            comm_loss <= next_comm_loss;
            comm_loss_action <= next_comm_loss_action;
        end
    end

    // Protection outputs and rate selection
    logic next_dyn_brake_on;
    logic next_regen_on;
    logic next_overspeed_alarm;
    logic [RATE_W-1:0] next_active_rate;

    always_comb
    begin
        next_dyn_brake_on = brake_req
            && (speed_mag <= {10'h000, brake_activation_speed});
        next_regen_on = (bus_voltage > dump_voltage_level);
        next_overspeed_alarm = overspeed_alarm && !overspeed_clear;
        if (speed_mag > {9'h000, max_velocity_setting})
        begin
            next_overspeed_alarm = 1'b1;
        end
        if (estop_cmd || lim_sync)
        begin
            next_active_rate = max_accel_setting;
        end
        else if (jog_active || osc_mode_active)
        begin
            next_active_rate = jog_decel_setting;
        end
        else if (commanded_rate > max_accel_setting)
        begin
            next_active_rate = max_accel_setting;
        end
        else
        begin
            next_active_rate = commanded_rate;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            dyn_brake_on <= 1'b0;
            regen_on <= 1'b0;
            overspeed_alarm <= 1'b0;
            active_rate <= MAX_ACCEL_RESET;
        end
        else
        begin
            dyn_brake_on <= next_dyn_brake_on;
            regen_on <= next_regen_on;
            overspeed_alarm <= next_overspeed_alarm;
            active_rate <= next_active_rate;
        end
    end

    // Jog settings
    logic signed [7:0] next_jog_speed;
    logic [RATE_W-1:0] next_jog_accel;
    logic [RATE_W-1:0] next_jog_decel;
    logic next_query_valid;
    logic [RATE_W-1:0] next_query_data;
    logic next_refused;

    always_comb
    begin
        next_jog_speed = jog_speed_setting;
        next_jog_accel = jog_accel_setting;
        next_jog_decel = jog_decel_setting;
        next_query_valid = 1'b0;
        next_query_data = jog_query_data;
        next_refused = 1'b0;
        if (jog_speed_wr)
        begin
            next_jog_speed = jog_speed_wdata;
        end
        if (jog_accel_query)
        begin
            next_query_valid = 1'b1;
            next_query_data = jog_accel_setting;
        end
        else if ((jog_accel_wr || jog_decel_wr) && jog_active)
        begin
            next_refused = 1'b1;
        end
        else if (jog_accel_wr)
        begin
            next_jog_accel = jog_rate_wdata;
            next_jog_decel = jog_rate_wdata;
        end
        else if (jog_decel_wr)
        begin
            next_jog_decel = jog_rate_wdata;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            jog_speed_setting <= JOG_SPEED_RESET;
            jog_accel_setting <= JOG_RATE_RESET;
            jog_decel_setting <= JOG_RATE_RESET;
            jog_query_valid <= 1'b0;
            jog_query_data <= '0;
            jog_write_refused <= 1'b0;
        end
        else
        begin
            jog_speed_setting <= next_jog_speed;
            jog_accel_setting <= next_jog_accel;
            jog_decel_setting <= next_jog_decel;
            jog_query_valid <= next_query_valid;
            jog_query_data <= next_query_data;
            jog_write_refused <= next_refused;
        end
    end

    assign jog_reverse = jog_speed_setting[7];

    // Jerk smoothing path
    assign jif.cmd_pos = cmd_position;
    assign jif.ms_tick = ms_tick;
    assign jif.time_const = jerk_time_setting;
    assign filtered_position = jif.filt_pos;

    sml_jerk_filter u_jerk
    (
        .mclk(mclk),
        .resetn(resetn),
        .jif(jif)
    );
endmodule

// ### rtl/sml_pkg.sv
// Purpose: Shared constants and types for the servo motion limits and watchdog block
// Assumes: Speeds in whole rps, rates in milli-rps/s, voltage in 0.1 V steps, times in ms
// Notes: Timing counts derive from the clock period
package sml_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_TIME_NS = 1000000;
    localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

    localparam int SPEED_W = 16;
    localparam int RATE_W = 23;
    localparam int POS_W = 32;

    localparam logic [14:0] ERR_BRAKE_TIME_RESET = 15'h0000;
    localparam logic [5:0] BRAKE_SPEED_RESET = 6'h32;
    localparam logic [13:0] WDOG_TIME_RESET = 14'h01f4;
    localparam logic [4:0] WDOG_ACTION_RESET = 5'h01;
    localparam logic [9:0] DUMP_LEVEL_RESET = 10'h28a;
    localparam logic [6:0] MAX_VEL_RESET = 7'h50;
    localparam logic [RATE_W-1:0] MAX_ACCEL_RESET = 23'h2dc6c0;
    localparam logic [7:0] JOG_SPEED_RESET = 8'h0a;
    localparam logic [RATE_W-1:0] JOG_RATE_RESET = 23'h0186a0;
    localparam logic [6:0] JERK_TIME_RESET = 7'h0a;

    // Error brake selector bit positions
    localparam int SEL_DECEL_BIT = 1;
    localparam int SEL_STOP_BIT = 0;

    typedef enum logic [2:0] {
        SML_IDLE = 3'b001,
        SML_DECEL = 3'b010,
        SML_STOP = 3'b100
    } sml_brake_state_type;

    function automatic logic [SPEED_W-1:0] sml_abs(input logic signed [SPEED_W-1:0] v);
        sml_abs = v[SPEED_W-1] ? SPEED_W'(-v) : v;
    endfunction
endpackage

// ### rtl/sml_jerk_if.sv
// Purpose: Carries the command path between the limits block and the jerk filter
// Assumes: One clock domain
// Notes: None
`timescale 1ns/10ps
interface sml_jerk_if
    import sml_pkg::*;
();
    logic signed [POS_W-1:0] cmd_pos;
    logic signed [POS_W-1:0] filt_pos;
    logic ms_tick;
    logic [6:0] time_const;
    modport ctrl (output cmd_pos, output ms_tick, output time_const, input filt_pos);
    modport filt (input cmd_pos, input ms_tick, input time_const, output filt_pos);
endinterface

// ### rtl/sml_jerk_filter.sv
// Purpose: Jerk smoothing of the position command
// Assumes: Updates once per millisecond tick, or every cycle when the time constant is zero
// Notes: Each step is at least one count toward the command, so the output lands exactly
`timescale 1ns/10ps
module sml_jerk_filter
    import sml_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    sml_jerk_if.filt jif
);
    logic signed [POS_W-1:0] out_pos;
    logic signed [POS_W-1:0] next_out_pos;
    logic signed [POS_W:0] diff;
    logic signed [POS_W:0] step;

    always_comb
    begin
        diff = {jif.cmd_pos[POS_W-1], jif.cmd_pos} - {out_pos[POS_W-1], out_pos};
        step = diff / $signed({1'b0, 25'h0, jif.time_const});
        next_out_pos = out_pos;
        if (jif.time_const == 7'h00)
        begin
            next_out_pos = jif.cmd_pos;
        end
        else if (jif.ms_tick && diff != '0)
        begin
            // Delay grows with the time constant, end point unchanged
            if (step == '0)
            begin
                next_out_pos = diff[POS_W] ? out_pos - 1 : out_pos + 1;
            end
            else
            begin
                next_out_pos = out_pos + step[POS_W-1:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            out_pos <= '0;
        end
        else
        begin
            out_pos <= next_out_pos;
        end
    end

    assign jif.filt_pos = out_pos;
endmodule

// ### testbench/sml_limits_monitor.sv
// Purpose: Port-level assertions for the limits block
// Assumes: Bound into sml_limits, one clock domain
// Notes: Watchdog bound assumes a three-millisecond setting
`timescale 1ns/10ps
module sml_limits_monitor
    import sml_pkg::*;
#(
    parameter int MS_DIV = 10
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic signed [SPEED_W-1:0] motor_speed,
    input wire logic [5:0] brake_activation_speed,
    input wire logic [9:0] bus_voltage,
    input wire logic [9:0] dump_voltage_level,
    input wire logic net_msg_strobe,
    input wire logic [13:0] comm_watchdog_time,
    input wire logic [4:0] comm_watchdog_action,
    input wire logic comm_loss_clear,
    input wire logic [6:0] max_velocity_setting,
    input wire logic overspeed_clear,
    input wire logic [RATE_W-1:0] max_accel_setting,
    input wire logic estop_cmd,
    input wire logic jog_active,
    input wire logic jog_accel_wr,
    input wire logic jog_accel_query,
    input wire logic [RATE_W-1:0] jog_rate_wdata,
    input wire logic dyn_brake_on,
    input wire logic regen_on,
    input wire logic comm_loss,
    input wire logic [4:0] comm_loss_action,
    input wire logic overspeed_alarm,
    input wire logic [RATE_W-1:0] active_rate,
    input wire logic [RATE_W-1:0] jog_accel_setting,
    input wire logic [RATE_W-1:0] jog_decel_setting,
    input wire logic jog_write_refused
);
    localparam int WD_MAX = 3 * MS_DIV + 2;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_msg_armed;
        net_msg_strobe && comm_watchdog_time == 14'h0003;
    endsequence
    sequence s_jog_write;
        jog_accel_wr && !jog_accel_query;
    endsequence
    a_regen_above: assert property (bus_voltage > dump_voltage_level |=> regen_on)
        else $error("regen resistor not switched on");
    a_overspeed_set: assert property (
        !motor_speed[15] && motor_speed > $signed({9'h000, max_velocity_setting})
        |=> overspeed_alarm)
        else $error("overspeed alarm missing");
    a_overspeed_held: assert property (
        overspeed_alarm && !overspeed_clear |=> overspeed_alarm)
        else $error("overspeed alarm dropped");
    a_loss_held: assert property (comm_loss && !comm_loss_clear |=> comm_loss)
        else $error("comm loss dropped");
    a_wdog_expires: assert property (
        s_msg_armed |=> ##[0:WD_MAX] (comm_loss || net_msg_strobe))
        else $error("watchdog did not expire in time");
    a_loss_action: assert property (
        $rose(comm_loss) |-> comm_loss_action == $past(comm_watchdog_action))
        else $error("wrong comm loss action");
    a_estop_rate: assert property (estop_cmd |=> active_rate == $past(max_accel_setting))
        else $error("stop rate is not the maximum");
    a_jog_refused: assert property (
        jog_active ##0 s_jog_write |=> jog_write_refused && $stable(jog_accel_setting))
        else $error("jog rate changed while jogging");
    a_jog_pair: assert property (
        !jog_active ##0 s_jog_write |=> jog_accel_setting == $past(jog_rate_wdata)
        && jog_decel_setting == $past(jog_rate_wdata))
        else $error("jog accel write did not load both rates");
    a_brake_fast: assert property (
        !motor_speed[15] && motor_speed > $signed({10'h000, brake_activation_speed})
        |=> !dyn_brake_on)
        else $error("brake applied above activation speed");
endmodule
bind sml_limits sml_limits_monitor #(.MS_DIV(MS_DIV)) sml_limits_monitor_inst (.*);

// ### testbench/sml_drive_model.sv
// Purpose: Network host and motor power stage facing the limits block
// Assumes: Motor speed follows the demanded speed one cycle late
// Notes: One message strobe per rising request
`timescale 1ns/10ps
module sml_drive_model
(
    input wire logic mclk,
    input wire logic msg_req,
    input wire logic signed [15:0] speed_cmd,
    output logic net_msg_strobe,
    output logic signed [15:0] motor_speed
);
    logic req_seen;
    initial
    begin
        req_seen = 1'b0;
        net_msg_strobe = 1'b0;
        motor_speed = 16'sh0000;
    end
    always @(posedge mclk)
    begin
        net_msg_strobe <= msg_req && !req_seen;
        req_seen <= msg_req;
        motor_speed <= speed_cmd;
    end
endmodule

// ### testbench/sml_limits_tb_top.sv
// Purpose: Self-checking bench for the limits block
// Assumes: One millisecond shortened to ten cycles
// Notes: Ordinary cases in a table, awkward cases by hand
`timescale 1ns/10ps
module sml_limits_tb_top
    import sml_pkg::*;
;
    localparam int MS = 10;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic error_active, comm_loss_clear, overspeed_clear, estop_cmd, limit_switch_pin;
    logic jog_active, osc_mode_active, jog_speed_wr, jog_accel_wr, jog_accel_query;
    logic jog_decel_wr, msg_req, net_msg_strobe, dyn_brake_on, regen_on, comm_loss;
    logic overspeed_alarm, jog_reverse, jog_query_valid, jog_write_refused;
    logic signed [SPEED_W-1:0] speed_cmd, motor_speed;
    logic [SPEED_W-1:0] zero_speed_threshold;
    logic [14:0] error_brake_time_param;
    logic [1:0] error_brake_action_select;
    logic [5:0] brake_activation_speed;
    logic [9:0] bus_voltage, dump_voltage_level;
    logic [13:0] comm_watchdog_time;
    logic [4:0] comm_watchdog_action, comm_loss_action;
    logic [6:0] max_velocity_setting, jerk_time_setting;
    logic [RATE_W-1:0] max_accel_setting, commanded_rate, jog_rate_wdata, active_rate;
    logic [RATE_W-1:0] jog_accel_setting, jog_decel_setting, jog_query_data;
    logic signed [7:0] jog_speed_wdata, jog_speed_setting;
    logic signed [POS_W-1:0] cmd_position, filtered_position;
    int failures = 0;
    int comparisons = 0;
    typedef struct packed {
        logic [9:0] bv;
        logic [RATE_W-1:0] cr;
        logic [POS_W-1:0] pos;
        logic regen;
        logic [RATE_W-1:0] rate;
    } sml_row_type;
    sml_row_type rows [4] = '{
        '{10'h28b, 23'h000064, 32'h00000010, 1'b1, 23'h000064},
        '{10'h28a, 23'h2dc6c1, 32'hfffffffb, 1'b0, 23'h2dc6c0},
        '{10'h0c8, 23'h2dc6c0, 32'h7fffffff, 1'b0, 23'h2dc6c0},
        '{10'h352, 23'h4c4b40, 32'h00000000, 1'b1, 23'h2dc6c0}
    };
    sml_limits #(.MS_DIV(MS)) sml_limits_inst (.*);
    sml_drive_model sml_drive_model_inst (.mclk(mclk), .msg_req(msg_req),
        .speed_cmd(speed_cmd), .net_msg_strobe(net_msg_strobe), .motor_speed(motor_speed));
    always #2 mclk = ~mclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            failures++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        cyc(40000);
        failures++;
        give_verdict();
    end
    initial
    begin
        {error_active, comm_loss_clear, overspeed_clear, estop_cmd, limit_switch_pin} = '0;
        {jog_active, osc_mode_active, jog_speed_wr, jog_accel_wr, jog_accel_query} = '0;
        {jog_decel_wr, msg_req, jog_rate_wdata, commanded_rate, cmd_position} = '0;
        speed_cmd = 16'sh0000;
        zero_speed_threshold = 16'h0001;
        error_brake_time_param = 15'h0002;
        error_brake_action_select = 2'b10;
        brake_activation_speed = 6'h32;
        bus_voltage = 10'h0c8;
        dump_voltage_level = 10'h28a;
        comm_watchdog_time = 14'h0003;
        comm_watchdog_action = 5'h07;
        max_velocity_setting = 7'h50;
        max_accel_setting = 23'h2dc6c0;
        jog_speed_wdata = -8'sh05;
        jerk_time_setting = 7'h00;
        cyc(8);
        resetn = 1'b1;
        chk(32'(active_rate), 32'h2dc6c0);
        chk(32'(jog_accel_setting), 32'h186a0);
        chk(32'(jog_decel_setting), 32'h186a0);
        chk(32'(jog_speed_setting), 32'h0000000a);
        chk(32'(comm_loss_action), 32'h1);
        cyc(1);
        $display("Test reset done");
        foreach (rows[i])
        begin
            bus_voltage = rows[i].bv;
            commanded_rate = rows[i].cr;
            cmd_position = rows[i].pos;
            cyc(2);
            chk(32'(regen_on), 32'(rows[i].regen));
            chk(32'(active_rate), 32'(rows[i].rate));
            chk(filtered_position, rows[i].pos);
        end
        $display("Test table done");
        jog_rate_wdata = 23'h0003e8;
        pulse(jog_accel_wr);
        jog_rate_wdata = 23'h0007d0;
        pulse(jog_decel_wr);
        cyc(1);
        chk(32'(jog_accel_setting), 32'h3e8);
        chk(32'(jog_decel_setting), 32'h7d0);
        jog_active = 1'b1;
        jog_rate_wdata = 23'h000064;
        pulse(jog_accel_wr);
        chk(32'(jog_write_refused), 32'h1);
        pulse(jog_decel_wr);
        chk(32'(jog_decel_setting), 32'h7d0);
        chk(32'(active_rate), 32'h7d0);
        jog_active = 1'b0;
        osc_mode_active = 1'b1;
        cyc(2);
        chk(32'(active_rate), 32'h7d0);
        pulse(jog_accel_query);
        chk(32'(jog_query_valid), 32'h1);
        chk(32'(jog_query_data), 32'h3e8);
        chk(32'(jog_accel_setting), 32'h3e8);
        pulse(jog_speed_wr);
        chk(32'(jog_speed_setting), 32'hfffffffb);
        chk(32'(jog_reverse), 32'h1);
        $display("Test jog done");
        osc_mode_active = 1'b0;
        commanded_rate = 23'h000001;
        max_accel_setting = 23'h0000a7;
        for (int i = 0; i < 2; i++)
        begin
            estop_cmd = (i == 0);
            limit_switch_pin = (i == 1);
            cyc(4);
            chk(32'(active_rate), 32'ha7);
        end
        limit_switch_pin = 1'b0;
        cyc(4);
        chk(32'(active_rate), 32'h1);
        $display("Test stop rate done");
        speed_cmd = 16'sh0051;
        cyc(3);
        chk(32'(overspeed_alarm), 32'h1);
        speed_cmd = 16'sh0010;
        cyc(3);
        chk(32'(overspeed_alarm), 32'h1);
        pulse(overspeed_clear);
        chk(32'(overspeed_alarm), 32'h0);
        $display("Test overspeed done");
        pulse(msg_req);
        cyc(18);
        pulse(msg_req);
        cyc(18);
        chk(32'(comm_loss), 32'h0);
        for (int n = 0; n < 40 && comm_loss !== 1'b1; n++)
            cyc(1);
        chk(32'(comm_loss), 32'h1);
        chk(32'(comm_loss_action), 32'h7);
        cyc(30);
        chk(32'(comm_loss), 32'h1);
        pulse(comm_loss_clear);
        chk(32'(comm_loss), 32'h0);
        // A zero trigger time leaves the watchdog disarmed
        comm_watchdog_time = 14'h0000;
        pulse(msg_req);
        cyc(40);
        chk(32'(comm_loss), 32'h0);
        comm_watchdog_time = 14'h0003;
        $display("Test watchdog done");
        speed_cmd = 16'sh003c;
        error_active = 1'b1;
        cyc(5);
        chk(32'(dyn_brake_on), 32'h0);
        error_active = 1'b0;
        speed_cmd = 16'sh0014;
        cyc(3);
        error_active = 1'b1;
        cyc(6);
        chk(32'(dyn_brake_on), 32'h1);
        cyc(40);
        chk(32'(dyn_brake_on), 32'h0);
        error_active = 1'b0;
        error_brake_action_select = 2'b01;
        error_brake_time_param = 15'h0064;
        speed_cmd = 16'sh0000;
        cyc(3);
        error_active = 1'b1;
        cyc(6);
        chk(32'(dyn_brake_on), 32'h1);
        error_active = 1'b0;
        $display("Test brake done");
        for (int k = 0; k < 2; k++)
        begin
            jerk_time_setting = k ? 7'h7d : 7'h05;
            cmd_position = k ? -32'sh3e8 : 32'sh3e8;
            cyc(3);
            chk(32'(filtered_position == cmd_position), 32'h0);
            for (int n = 0; n < 9000 && filtered_position !== cmd_position; n++)
                cyc(1);
            chk(filtered_position, cmd_position);
        end
        $display("Test jerk done");
        give_verdict();
    end
endmodule
